/* verilog/ssvc_map.svh */
// constants of the serial symbol codec: rates, lengths, sync words
// assumes clk_i is the bit-rate clock of the link
`ifndef SSVC_MAP_SVH
`define SSVC_MAP_SVH
// ==========================================================
// timing
`define SSVC_CLK_MHZ      100
`define SSVC_BIT_MIN_MHZ  40
`define SSVC_BIT_MAX_MHZ  125
// bits per symbol, equal to the bit/byte rate multiplier
`define SSVC_MULT_W8      4'd10
`define SSVC_MULT_W9      4'd11
`define SSVC_MULT_W10     4'd12
// ==========================================================
// symbol layout
`define SSVC_SYM_W        12
`define SSVC_SYNC_W8      12'h311
`define SSVC_SYNC_W9      12'h311
`define SSVC_SYNC_W10     12'h623
`define SSVC_RST_WORD     12'h000
`endif

/* verilog/ssvc_pkg.sv */
// types and code tables of the serial symbol codec
// assumes ssvc_map.svh is on the include path
`include "ssvc_map.svh"
package ssvc_pkg;
    // ======================================================
    // types
    typedef enum logic [1:0] {SSVC_W8, SSVC_W9, SSVC_W10} ssvc_width_t;
    typedef enum logic {SSVC_HUNT, SSVC_LOCKED} ssvc_rx_state_t;
    // ======================================================
    // code tables
    localparam logic [4:0] SSVC_TBL5 [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
        5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    localparam logic [5:0] SSVC_TBL6 [32] = '{6'h36, 6'h11, 6'h24, 6'h25,
        6'h12, 6'h13, 6'h16, 6'h17, 6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
        6'h3e, 6'h19, 6'h29, 6'h2d, 6'h1a, 6'h1b, 6'h1e, 6'h1f, 6'h2a, 6'h2b, 6'h2e, 6'h2f,
        6'h3a, 6'h3b, 6'h3c, 6'h3d};
    // narrow command pairs, entry 0 unused
    localparam logic [9:0] SSVC_CMD8 [16] = '{10'h000, 10'h3ff, 10'h1ad, 10'h1b9,
        10'h3e4, 10'h1a7, 10'h327, 10'h339, 10'h084, 10'h09f, 10'h080, 10'h0e7, 10'h0f9,
        10'h004, 10'h01f, 10'h000};
    // ======================================================
    // helpers
    function automatic logic [3:0] ssvc_len(input ssvc_width_t m);
        return (m == SSVC_W10) ? `SSVC_MULT_W10 : (m == SSVC_W9) ? `SSVC_MULT_W9 : `SSVC_MULT_W8;
    endfunction
    function automatic logic [11:0] ssvc_sync(input ssvc_width_t m);
        return (m == SSVC_W10) ? `SSVC_SYNC_W10 : (m == SSVC_W9) ? `SSVC_SYNC_W9 : `SSVC_SYNC_W8;
    endfunction
    // wide form of a narrow command letter
    function automatic logic [5:0] ssvc_prime(input logic [4:0] x);
        return {x[4:3], 1'b1, x[2:0]};
    endfunction
    function automatic logic [11:0] ssvc_cmd_sym(input ssvc_width_t m, input logic [3:0] i);
        logic [9:0] c;
        c = SSVC_CMD8[i];
        if (m == SSVC_W10)
            return {ssvc_prime(c[9:5]), ssvc_prime(c[4:0])};
        else if (m == SSVC_W9)
            return {1'b0, ssvc_prime(c[9:5]), c[4:0]};
        return {2'b00, c};
    endfunction
    function automatic logic [11:0] ssvc_data_sym(input ssvc_width_t m, input logic [9:0] d);
        if (m == SSVC_W10)
            return {SSVC_TBL6[d[8:4]], SSVC_TBL6[{d[9], d[3:0]}]};
        else if (m == SSVC_W9)
            return {1'b0, SSVC_TBL6[d[8:4]], SSVC_TBL5[d[3:0]]};
        return {2'b00, SSVC_TBL5[d[7:4]], SSVC_TBL5[d[3:0]]};
    endfunction
endpackage

/* verilog/ssvc_symbol_decoder.sv */
// full decoder of one received symbol, purely combinational
// assumes the symbol sits right-aligned in symbol_i
`timescale 1ns/100ps
module ssvc_symbol_decoder (
    // symbol in
    input  wire ssvc_pkg::ssvc_width_t mode_i,
    input  wire logic [11:0]           symbol_i,
    // decode out
    output logic                       sync_o,
    output logic                       data_o,
    output logic                       cmd_o,
    output logic                       viol_o,
    output logic [9:0]                 data_val_o,
    output logic [3:0]                 cmd_val_o
);
    import ssvc_pkg::*;
    // ======================================================
    // half decode: {is_data, is_cmd, value}
    function automatic logic [6:0] half_dec(input logic [5:0] f, input logic w6);
        logic [6:0] r;
        r = 7'h00;
        if (w6)
        begin
            for (int i = 0; i < 32; i++)
                if (SSVC_TBL6[i] == f) r = {2'b10, 5'(i)};
            // wide command letters and sync halves
            if (f == 6'h3f || f == 6'h1d || f == 6'h39 || f == 6'h18 || f == 6'h23) r[5] = 1'b1;
        end
        else
        begin
            for (int i = 0; i < 16; i++)
                if ({1'b0, SSVC_TBL5[i]} == f) r = {2'b10, 5'(i)};
            if (f == 6'h1f || f == 6'h0d || f == 6'h19 || f == 6'h04 ||
                f == 6'h07 || f == 6'h00 || f == 6'h18 || f == 6'h11) r[5] = 1'b1;
        end
        return r;
    endfunction
    logic [5:0] up_f;   // upper half field
    logic [5:0] lo_f;   // lower half field
    logic [6:0] up_d;   // upper half decode
    logic [6:0] lo_d;   // lower half decode
    logic [3:0] hit;    // matching command index, 0 = none
    logic [3:0] cmax;   // last command of this width
    // ======================================================
    // split, classify, look up
    always_comb
    begin
        up_f = {1'b0, symbol_i[9:5]};
        lo_f = {1'b0, symbol_i[4:0]};
        cmax = 4'hf;
        if (mode_i == SSVC_W9)
        begin
            up_f = symbol_i[10:5];
            cmax = 4'h7;
        end
        else if (mode_i == SSVC_W10)
        begin
            up_f = symbol_i[11:6];
            lo_f = symbol_i[5:0];
            cmax = 4'h3;
        end
        up_d = half_dec(up_f, mode_i != SSVC_W8);
        lo_d = half_dec(lo_f, mode_i == SSVC_W10);
        hit = 4'h0;
        for (int i = 1; i < 16; i++)
            if (4'(i) <= cmax && ssvc_cmd_sym(mode_i, 4'(i)) == symbol_i) hit = 4'(i);
    end
    // ======================================================
    // verdict; invalid halves read as zero in the output
    always_comb
    begin
        sync_o = (symbol_i == ssvc_sync(mode_i));
        data_o = 1'b0;
        cmd_o = 1'b0;
        viol_o = 1'b0;
        cmd_val_o = hit;
        if (mode_i == SSVC_W10)
            data_val_o = {lo_d[4], up_d[4:0], lo_d[3:0]};
        else if (mode_i == SSVC_W9)
            data_val_o = {1'b0, up_d[4:0], lo_d[3:0]};
        else
            data_val_o = {2'b00, up_d[3:0], lo_d[3:0]};
        if (sync_o)
            data_o = 1'b0;                          // padding, no strobe
        else if (up_d[6] && lo_d[6])
            data_o = 1'b1;                          // clean data
        else if (up_d[5] && lo_d[5])
        begin
            cmd_o = 1'b1;                           // RL5
            viol_o = (hit == 4'h0);                 // RL4
        end
        else if ((up_d[5] && lo_d[6]) || (up_d[6] && lo_d[5]))
        begin
            cmd_o = 1'b1;                           // RL6
            cmd_val_o = 4'h0;
            viol_o = 1'b1;                          // RL4
        end
        else
        begin
            data_o = 1'b1;                          // RL5
            viol_o = 1'b1;                          // RL4
        end
    end
endmodule

/* verilog/ssvc_serial_codec.sv */
// serial symbol codec: transmit encoder/serialiser and receive framer
// assumes clk_i is the bit-rate clock, all inputs synchronous to it
//
// Function
// [RL1] sync symbols only pad idle byte slots
// [RL2] zero command with strobe sends data
// [RL3] host avoids repeating sparse-transition commands
// [RL4] receiver flags all four violation kinds
// [RL5] bad data or command still strobed
// [RL6] mixed halves output as command
// [RL7] violation flag accompanies the decoded output
// [RL8] host keeps its own error detection
// [RL9] eight-bit width: ten bits per byte
// [RL10] nine/ten-bit widths: eleven/twelve bits
// [RL11] bit clock within 40 to 125 MHz
// [RL12] both ends use equal byte reference
// [RL13] logic timed from bit clock, byte divided
// [RL14] local mode: clock out copies reference
// [RL15] reference is crystal or logic clock
// [RL16] recovered clock never feeds a reference
// [RL17] symbols leave most significant bit first
// [RL18] at most one strobe per symbol
`timescale 1ns/100ps
`include "ssvc_map.svh"
module ssvc_serial_codec (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    // configuration
    input  wire ssvc_pkg::ssvc_width_t width_mode_i,
    input  wire logic                  local_mode_i,
    input  wire logic                  reference_clock_in_i,
    // transmit host side
    input  wire logic                  word_strobe_i,
    input  wire logic [9:0]            tx_data_i,
    input  wire logic [3:0]            tx_command_i,
    output logic                       tx_accept_o,
    // transmit line side
    output logic                       serial_out_o,
    output logic                       clk_out_o,
    // receive line side
    input  wire logic                  serial_input_pair_i,
    // receive host side
    output logic [9:0]                 rx_data_o,
    output logic [3:0]                 rx_command_o,
    output logic                       word_strobe_o,
    output logic                       command_word_strobe_o,
    output logic                       violation_o,
    output logic                       rx_framed_o
);
    import ssvc_pkg::*;
    // ======================================================
    // transmit side
    logic [3:0]     sym_len;      // bits per symbol
    logic [3:0]     tx_cnt;       // bit position in symbol
    logic           tx_tick;      // last bit, byte-rate enable
    logic [3:0]     cmd_idx;      // command masked to width
    logic [11:0]    next_tx_sym;  // right-aligned symbol
    logic [11:0]    next_tx_aln;  // left-aligned symbol
    logic [11:0]    sync_aln;     // left-aligned sync
    logic [11:0]    tx_shift;     // serialiser
    assign sym_len = ssvc_len(width_mode_i);
    assign tx_tick = (tx_cnt == sym_len - 4'd1);
    assign tx_accept_o = word_strobe_i && tx_tick;
    // bit counter, divides the bit clock down to byte rate
    always_ff @(posedge clk_i)
    begin
        if (srst_i || tx_tick)
            tx_cnt <= 4'd0;                          // RL9 RL10 RL13
        else
            tx_cnt <= tx_cnt + 4'd1;
    end
    // symbol choice: command, data, else sync padding
    always_comb
    begin
        if (width_mode_i == SSVC_W10)
            cmd_idx = {2'b00, tx_command_i[1:0]};
        else if (width_mode_i == SSVC_W9)
            cmd_idx = {1'b0, tx_command_i[2:0]};
        else
            cmd_idx = tx_command_i;
        if (word_strobe_i && cmd_idx != 4'h0)
            next_tx_sym = ssvc_cmd_sym(width_mode_i, cmd_idx);
        else if (word_strobe_i)
            next_tx_sym = ssvc_data_sym(width_mode_i, tx_data_i);    // RL2
        else
            next_tx_sym = ssvc_sync(width_mode_i);                   // RL1
        // left align so bit 11 always leaves first
        next_tx_aln = next_tx_sym << (4'd12 - sym_len);
        sync_aln = ssvc_sync(width_mode_i) << (4'd12 - sym_len);
    end
    // serialiser: load at the byte boundary, then shift left
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            tx_shift <= `SSVC_RST_WORD;
        else if (tx_tick)
            tx_shift <= next_tx_aln;                 // RL1
        else
            tx_shift <= {tx_shift[10:0], 1'b0};      // RL17
    end
    assign serial_out_o = tx_shift[11];
    // clock output; in local mode it copies the reference, otherwise it shows the byte tick
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            clk_out_o <= 1'b0;
        else if (local_mode_i)
            clk_out_o <= reference_clock_in_i;       // RL14
        else
            clk_out_o <= tx_tick;
    end
    // ======================================================
    // receive side
    ssvc_rx_state_t rx_state;     // framing state
    logic [3:0]     rx_cnt;       // bits since boundary
    logic [11:0]    rx_sh;        // received bits
    logic [11:0]    next_rx_sh;   // with the new bit
    logic [11:0]    rx_win;       // one symbol window
    logic           sync_hit;     // window holds sync
    logic           boundary;     // window holds a framed symbol
    logic           dec_sync;
    logic           dec_data;
    logic           dec_cmd;
    logic           dec_viol;
    logic [9:0]     dec_dval;
    logic [3:0]     dec_cval;
    assign next_rx_sh = {rx_sh[10:0], serial_input_pair_i};
    assign rx_win = next_rx_sh & (12'hfff >> (4'd12 - sym_len));
    assign sync_hit = (rx_win == ssvc_sync(width_mode_i));
    assign boundary = (rx_state == SSVC_LOCKED) && (rx_cnt == sym_len - 4'd1);
    assign rx_framed_o = (rx_state == SSVC_LOCKED);
    // bit shifter
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rx_sh <= `SSVC_RST_WORD;
        else
            rx_sh <= next_rx_sh;
    end
    // framing: any sync realigns, so a symbol may stretch but never shorten
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rx_state <= SSVC_HUNT;
        else if (sync_hit)
            rx_state <= SSVC_LOCKED;
    end
    always_ff @(posedge clk_i)
    begin
        if (srst_i || sync_hit || boundary || rx_state == SSVC_HUNT)
            rx_cnt <= 4'd0;
        else
            rx_cnt <= rx_cnt + 4'd1;
    end
    ssvc_symbol_decoder u_dec (
        .mode_i     (width_mode_i),
        .symbol_i   (rx_win),
        .sync_o     (dec_sync),
        .data_o     (dec_data),
        .cmd_o      (dec_cmd),
        .viol_o     (dec_viol),
        .data_val_o (dec_dval),
        .cmd_val_o  (dec_cval)
    );
    // strobes: one-cycle pulses, decoder gives at most one kind
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !boundary)
        begin
            word_strobe_o <= 1'b0;
            command_word_strobe_o <= 1'b0;
            violation_o <= 1'b0;
        end
        else
        begin
            word_strobe_o <= dec_data;               // RL18
            command_word_strobe_o <= dec_cmd;        // RL5 RL6
            violation_o <= dec_viol;                 // RL7
        end
    end
    // output words hold until the next strobe of their kind
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rx_data_o <= 10'h000;
            rx_command_o <= 4'h0;
        end
        else if (boundary && dec_data)
            rx_data_o <= dec_dval;
        else if (boundary && dec_cmd)
            rx_command_o <= dec_cval;
    end
    // ======================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // helper: cycles since the last byte tick; counted apart from tx_cnt
    // so that a wrong wrap point in the divider shows up here
    logic [3:0]     tick_gap;     // cycles since the last tick
    always_ff @(posedge clk_i)
    begin
        if (srst_i || tx_tick)
            tick_gap <= 4'd0;
        else
            tick_gap <= tick_gap + 4'd1;
    end
    // first two line bits after a load
    sequence s_first_two_bits;
        serial_out_o == $past(next_tx_aln[11]) ##1 serial_out_o == $past(next_tx_aln[10], 2);
    endsequence
    a_rate_eight: assert property (tx_tick && width_mode_i == SSVC_W8 |-> tick_gap == (`SSVC_MULT_W8 - 4'd1)) // RL9
        else $error("byte period not 10 bits");
    a_rate_nine: assert property (tx_tick && width_mode_i == SSVC_W9 |-> tick_gap == (`SSVC_MULT_W9 - 4'd1)) // RL10
        else $error("byte period not 11 bits");
    a_rate_ten: assert property (tx_tick && width_mode_i == SSVC_W10 |-> tick_gap == (`SSVC_MULT_W10 - 4'd1)) // RL10
        else $error("byte period not 12 bits");
    a_bit_range: assert property (`SSVC_CLK_MHZ >= `SSVC_BIT_MIN_MHZ && `SSVC_CLK_MHZ <= `SSVC_BIT_MAX_MHZ) // RL11
        else $error("bit clock out of range");
    a_host_no_sync: assert property (tx_accept_o |=> tx_shift != $past(sync_aln)) // RL1
        else $error("host strobe produced sync");
    a_idle_sync: assert property (tx_tick && !word_strobe_i |=> tx_shift == $past(sync_aln)) // RL1
        else $error("idle slot not padded");
    a_msb_first: assert property (tx_tick |=> s_first_two_bits) // RL17
        else $error("symbol bit order wrong");
    a_clk_local: assert property (local_mode_i |=> clk_out_o == $past(reference_clock_in_i)) // RL14
        else $error("clock out not reference copy");
    a_mixed_cmd: assert property (boundary && dec_cmd && dec_viol
        |=> command_word_strobe_o && violation_o && !word_strobe_o) // RL6
        else $error("violating command not strobed");
    a_bad_data: assert property (boundary && dec_data && dec_viol |=> word_strobe_o && violation_o) // RL5
        else $error("bad data not strobed");
    a_flag_match: assert property (boundary && !dec_sync |=> violation_o == $past(dec_viol)) // RL4 RL7
        else $error("violation flag lost");
    a_one_strobe: assert property ((word_strobe_o || command_word_strobe_o)
        |-> !(word_strobe_o && command_word_strobe_o) ##1 !(word_strobe_o || command_word_strobe_o)) // RL18
        else $error("strobe doubled");
endmodule

/* testbench/ssvc_peer_model.sv */
// peer transmitter model that feeds the codec receive line
// assumes eight-bit width: ten-bit symbols, sync fill while the queue is empty
`timescale 1ns/100ps
`include "ssvc_map.svh"
module ssvc_peer_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // line toward the receiver
    output logic      serial_o
);
    import ssvc_pkg::*;
    // ==========================================================
    // symbol source
    localparam int          LEN    = 10;            // same byte rate as the codec
    localparam logic [11:0] SYNC12 = `SSVC_SYNC_W8; // fill pattern
    logic [9:0] queue_q [$];                        // symbols waiting to go out
    logic [9:0] shift    = 10'h000;                 // symbol on the line
    int         cnt      = 0;                       // bit position in symbol
    // the bench queues symbols here; each goes out once, so no repeats
    task automatic push(input logic [9:0] sym);
        queue_q.push_back(sym);
    endtask
    // ==========================================================
    // one bit per clock, msb first, moved off the sampling edge
    always @(negedge clk_i)
    begin
        if (srst_i)
        begin
            cnt = 0;
            serial_o <= 1'b0;
        end
        else
        begin
            // idle slots carry sync so the receiver keeps framing
            if (cnt == 0)
                shift = (queue_q.size() != 0) ? queue_q.pop_front() : SYNC12[9:0];
            serial_o <= shift[9];
            shift = shift << 1;
            cnt = (cnt == LEN - 1) ? 0 : cnt + 1;
        end
    end
endmodule

/* testbench/ssvc_serial_codec_tb.sv */
// self-checking bench of the serial symbol codec
// assumes the peer model drives the receive line in eight-bit width
`timescale 1ns/100ps
`include "ssvc_map.svh"
module ssvc_serial_codec_tb;
    import ssvc_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic        clk_i = 1'b0, srst_i = 1'b1, local_mode_i = 1'b0;
    ssvc_width_t width_mode_i = SSVC_W8;
    logic        reference_clock_in_i = 1'b0, word_strobe_i = 1'b0;
    logic [9:0]  tx_data_i = 10'h000;
    logic [3:0]  tx_command_i = 4'h0;
    logic        tx_accept_o, serial_out_o, clk_out_o, serial_input_pair_i;
    logic [9:0]  rx_data_o;
    logic [3:0]  rx_command_o;
    logic        word_strobe_o, command_word_strobe_o, violation_o, rx_framed_o;
    int          miscompares = 0, tests_run = 0, cycles = 0, ref_cnt = 0;
    ssvc_serial_codec dut (.clk_i(clk_i), .srst_i(srst_i), .width_mode_i(width_mode_i),
        .local_mode_i(local_mode_i), .reference_clock_in_i(reference_clock_in_i),
        .word_strobe_i(word_strobe_i), .tx_data_i(tx_data_i), .tx_command_i(tx_command_i),
        .tx_accept_o(tx_accept_o), .serial_out_o(serial_out_o), .clk_out_o(clk_out_o),
        .serial_input_pair_i(serial_input_pair_i), .rx_data_o(rx_data_o),
        .rx_command_o(rx_command_o), .word_strobe_o(word_strobe_o),
        .command_word_strobe_o(command_word_strobe_o), .violation_o(violation_o),
        .rx_framed_o(rx_framed_o));
    ssvc_peer_model peer (.clk_i(clk_i), .srst_i(srst_i), .serial_o(serial_input_pair_i));
    // ==========================================================
    // clocks, monitors and the hang guard
    always #5 clk_i = ~clk_i; // 100 MHz bit clock, inside its legal range
    // slow logic-level reference, toggled every eight cycles
    // made here on its own, never from the receive side
    always @(negedge clk_i)
    begin
        ref_cnt = (ref_cnt == 7) ? 0 : ref_cnt + 1;
        if (ref_cnt == 0)
            reference_clock_in_i <= ~reference_clock_in_i;
    end
    // strobes are exclusive and a violation never stands alone
    always @(negedge clk_i)
    begin
        if (!srst_i && word_strobe_o === 1'b1 && command_word_strobe_o === 1'b1)
            fail("both strobes together");
        if (!srst_i && violation_o === 1'b1 && !(word_strobe_o || command_word_strobe_o))
            fail("violation without strobe");
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail("timeout");
            give_verdict();
        end
    end
    // ==========================================================
    // shared helpers
    task automatic fail(input string msg);
        miscompares++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
            fail(msg);
    endtask
    task automatic do_reset(input ssvc_width_t mode);
        srst_i = 1'b1;
        width_mode_i = mode;
        repeat (20) @(negedge clk_i);
        check(rx_framed_o === 1'b0 && word_strobe_o === 1'b0 && serial_out_o === 1'b0, "reset values");
        check(clk_out_o === 1'b0 && command_word_strobe_o === 1'b0, "reset clock out");
        srst_i = 1'b0;
    endtask
    // waits for the slot that takes the held strobe, bounded
    task automatic wait_accept();
        int n;
        #1;
        n = 0;
        while (tx_accept_o !== 1'b1 && n < 30)
        begin
            @(negedge clk_i);
            #1;
            n++;
        end
        check(n < 30, "no accept");
    endtask
    // ten line bits after a taken slot, strobe released on the way
    task automatic collect(output logic [9:0] sym);
        sym = 10'h000;
        for (int k = 0; k < 10; k++)
        begin
            @(negedge clk_i);
            if (k == 0)
                word_strobe_i = 1'b0;
            sym = {sym[8:0], serial_out_o};
        end
    endtask
    task automatic tx_send(input logic [3:0] cmd, input logic [9:0] data, input logic [9:0] exp);
        logic [9:0] sym;
        word_strobe_i = 1'b1;
        tx_command_i = cmd;
        tx_data_i = data;
        wait_accept();
        collect(sym);
        check(sym === exp, "transmit symbol");
        check(sym !== 10'h311, "host input sent sync");
    endtask
    task automatic rx_expect(input logic [9:0] sym, input logic is_cmd, input logic [9:0] val,
                             input logic viol);
        int n;
        peer.push(sym);
        n = 0;
        while (word_strobe_o !== 1'b1 && command_word_strobe_o !== 1'b1 && n < 40)
        begin
            @(negedge clk_i);
            n++;
        end
        check(n < 40, "no receive strobe");
        check(command_word_strobe_o === is_cmd, "strobe kind");
        check(is_cmd ? (rx_command_o === val[3:0]) : (rx_data_o === val), "decoded value");
        check(violation_o === viol, "violation flag");
        @(negedge clk_i);
    endtask
    // ==========================================================
    // scenarios
    task automatic test_tx();
        logic [9:0] sym;
        tx_send(4'h0, 10'h0a5, {SSVC_TBL5[4'ha], SSVC_TBL5[4'h5]});
        collect(sym);
        check(sym === 10'h311, "idle slot not sync");
        for (int i = 1; i < 16; i++)
            tx_send(4'(i), 10'h0ff, SSVC_CMD8[i]);
    endtask
    task automatic test_rx();
        check(rx_framed_o === 1'b1, "receiver not framed");
        rx_expect({SSVC_TBL5[4'h3], SSVC_TBL5[4'hc]}, 1'b0, 10'h03c, 1'b0);
        for (int i = 1; i < 16; i++)
            rx_expect(SSVC_CMD8[i], 1'b1, 10'(i), 1'b0);
        rx_expect({SSVC_TBL5[4'h4], 5'b00001}, 1'b0, 10'h040, 1'b1);
        rx_expect({5'b11111, SSVC_TBL5[4'h3]}, 1'b1, 10'h000, 1'b1);
        rx_expect({SSVC_TBL5[4'h3], 5'b11111}, 1'b1, 10'h000, 1'b1);
        rx_expect({5'b11111, 5'b11001}, 1'b1, 10'h000, 1'b1);
    endtask
    // local mode passes the reference through once it has settled
    task automatic test_local();
        local_mode_i = 1'b1;
        repeat (64)
        begin
            @(negedge clk_i);
            if (ref_cnt >= 4)
                check(clk_out_o === reference_clock_in_i, "clock out not reference");
        end
        local_mode_i = 1'b0;
    endtask
    // slot spacing equals bits per symbol for each width, then the word taken
    task automatic test_rate(input ssvc_width_t mode, input int exp_len, input logic [11:0] exp_sym);
        int n;
        logic [11:0] sym;
        do_reset(mode);
        tx_command_i = 4'h0;
        tx_data_i = 10'h0ff;
        word_strobe_i = 1'b1;
        wait_accept();
        n = 0;
        do
        begin
            @(negedge clk_i);
            #1;
            n++;
        end
        while (tx_accept_o !== 1'b1 && n < 30);
        check(n == exp_len, "slot spacing");
        // strobe held over the taking edge, released on the falling edge after
        sym = 12'h000;
        for (int k = 0; k < exp_len; k++)
        begin
            @(negedge clk_i);
            if (k == 0)
            begin
                word_strobe_i = 1'b0;
                check(clk_out_o === 1'b1, "byte tick not on clock out");
            end
            sym = {sym[10:0], serial_out_o};
        end
        check(sym === exp_sym, "wide symbol");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        @(negedge clk_i);
        do_reset(SSVC_W8);
        repeat (40) @(negedge clk_i);
        test_tx();
        test_rx();
        test_local();
        // data 0ff: f/f codes, then 0f (6b) with f (5b), then 0f (6b) twice
        test_rate(SSVC_W8, 10, 12'h3bd);
        test_rate(SSVC_W9, 11, 12'h6bd);
        test_rate(SSVC_W10, 12, 12'hd75);
        give_verdict();
    end
endmodule
